/* hdl/scoc_pkg.sv */
package scoc_pkg;

  // Bus geometry
  localparam int unsigned SCOC_ADR_W = 8;

  // Register byte offsets
  localparam logic [7:0] SCOC_OFF_SLEEP_CTRL  = 8'h00;
  localparam logic [7:0] SCOC_OFF_REG_CTRL    = 8'h04;
  localparam logic [7:0] SCOC_OFF_SLEEP_STAT  = 8'h08;
  localparam logic [7:0] SCOC_OFF_MCLK_STAT   = 8'h0C;
  localparam logic [7:0] SCOC_OFF_XOSC_CTRL   = 8'h1C;

  // Crystal oscillator control field positions
  localparam int unsigned SCOC_XO_RUN_IN_STANDBY = 7;
  localparam int unsigned SCOC_XO_CRYSTAL_STARTUP_TIME_LSB = 4;
  localparam int unsigned SCOC_XO_SEL      = 2;
  localparam int unsigned SCOC_XO_OSC_LOW_POWER   = 1;
  localparam int unsigned SCOC_XO_ENABLE   = 0;

  // Sleep control and regulator control field positions
  localparam int unsigned SCOC_SC_SEN      = 0;
  localparam int unsigned SCOC_SC_MODE_LSB = 1;
  localparam int unsigned SCOC_RC_REGULATOR_POWER_MODE    = 0;

  // Values after reset
  localparam logic [7:0] SCOC_XOSC_CTRL_RST  = 8'h00;
  localparam logic       SCOC_SEN_RST        = 1'h0;
  localparam logic [1:0] SCOC_SLEEP_MODE_SELECT_RST      = 2'h0;
  localparam logic       SCOC_REGULATOR_POWER_MODE_RST      = 1'h0;

  // Sleep mode codes, code 3 is reserved and never enters sleep
  localparam logic [1:0] SCOC_SLEEP_MODE_SELECT_IDLE  = 2'h0;
  localparam logic [1:0] SCOC_SLEEP_MODE_SELECT_STDBY = 2'h1;
  localparam logic [1:0] SCOC_SLEEP_MODE_SELECT_PDOWN = 2'h2;

  // Regulator power modes
  localparam logic SCOC_REGULATOR_POWER_MODE_AUTO = 1'h0;
  localparam logic SCOC_REGULATOR_POWER_MODE_FULL = 1'h1;

  // Start-up counts in oscillator cycles
  localparam logic [16:0] SCOC_SU_1K   = 17'h00400;
  localparam logic [16:0] SCOC_SU_16K  = 17'h04000;
  localparam logic [16:0] SCOC_SU_32K  = 17'h08000;
  localparam logic [16:0] SCOC_SU_64K  = 17'h10000;
  localparam logic [16:0] SCOC_SU_EXT  = 17'h00001;
  localparam logic [1:0]  SCOC_AVAIL_TICKS = 2'h2;

  // Wake-capable interrupt lines per sleep mode
  localparam logic [7:0] SCOC_WAKE_IDLE  = 8'hFF;
  localparam logic [7:0] SCOC_WAKE_STDBY = 8'h3F;
  localparam logic [7:0] SCOC_WAKE_PDOWN = 8'h0F;

  typedef enum logic [1:0] {
    SCOC_ST_ACTIVE  = 2'b00,
    SCOC_ST_IDLE    = 2'b01,
    SCOC_ST_STANDBY = 2'b10,
    SCOC_ST_PDOWN   = 2'b11
  } scoc_state_t;

  typedef struct packed {
    logic       run_in_standby;
    logic [1:0] crystal_startup_time;
    logic       ext_clock_sel;
    logic       osc_low_power;
    logic       osc_enable;
  } scoc_xosc_ctrl_t;

endpackage

/* hdl/scoc_startup_timer.sv */
module scoc_startup_timer (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Oscillator state
  input  wire logic        enable_i,
  input  wire logic        run_i,
  input  wire logic        tick_i,
  input  wire logic [16:0] limit_i,
  input  wire logic        req_i,
  // Results
  output logic             ready_o,
  output logic             avail_o
);

  logic [16:0] cnt_r;
  logic [1:0]  av_cnt_r;

  // Start-up counts only oscillator edges while the oscillator runs
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !enable_i)
    begin
      cnt_r   <= 17'h00000;
      ready_o <= 1'b0;
    end
    else if (run_i && tick_i && !ready_o)
    begin
      cnt_r <= cnt_r + 17'h00001;
      if (cnt_r + 17'h00001 == limit_i)
        ready_o <= 1'b1;
    end
  end

  // Requested output appears a fixed number of edges after start-up
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !ready_o || !run_i || !req_i)
    begin
      av_cnt_r <= 2'h0;
      avail_o  <= 1'b0;
    end
    else if (tick_i && !avail_o)
    begin
      av_cnt_r <= av_cnt_r + 2'h1;
      if (av_cnt_r + 2'h1 == scoc_pkg::SCOC_AVAIL_TICKS)
        avail_o <= 1'b1; // R3
    end
  end

endmodule

/* hdl/scoc_wake_filter.sv */
module scoc_wake_filter (
  // Sleep state
  input  wire scoc_pkg::scoc_state_t state_i,
  // Interrupt sources
  input  wire logic [7:0]            irq_i,
  input  wire logic                  gie_i,
  // Wake request
  output logic                       wake_o
);

  function automatic logic [7:0] wake_mask(input scoc_pkg::scoc_state_t st);
    case (st)
      scoc_pkg::SCOC_ST_IDLE:    wake_mask = scoc_pkg::SCOC_WAKE_IDLE;
      scoc_pkg::SCOC_ST_STANDBY: wake_mask = scoc_pkg::SCOC_WAKE_STDBY;
      scoc_pkg::SCOC_ST_PDOWN:   wake_mask = scoc_pkg::SCOC_WAKE_PDOWN;
      default:                   wake_mask = 8'h00;
    endcase
  endfunction

  // Without global enable nothing but a reset brings the core back
  assign wake_o = gie_i && (|(irq_i & wake_mask(state_i))); // R12

endmodule

/* hdl/scoc_top.sv */
// How it works
// R1: Without standby-run the crystal runs only on request, only in Active and Idle.
// R2: With standby-run and enable set the crystal runs in every mode.
// R3: After start-up a requested crystal output appears within three oscillator cycles.
// R4: Start-up field selects 1k, 16k, 32k or 64k cycles for a crystal.
// R5: Start-up field and source select are frozen while enabled or status set.
// R6: Source select picks crystal on both pins or external clock on pin one.
// R7: Low-power bit puts the crystal in low-power mode; may slow start-up.
// R8: Enable bit starts the crystal and hands its pins to the oscillator.
// R9: Active plus Idle, Standby and Power-Down, each entered straight from Active.
// R10: Any sleep mode halts the CPU until a wake-up event.
// R11: Enabled wake interrupt wakes; CPU runs the handler then resumes after sleep.
// R12: Which interrupts can wake depends on the configured sleep mode.
// R13: Any reset during sleep ends sleep and restarts from the reset vector; cpu_reset_vector_o pulses for reset_src_i only, not for rst_i.
// R14: Registers and memories keep their contents through every sleep mode.
// R15: Sleep needs mode and sleep-enable set, then the sleep instruction.
// R16: Software enables wake interrupts and global enable, else only reset wakes.
// R17: Auto regulator goes low-current asleep when only the internal slow oscillator runs.
// R18: Auto: fast clock full in Active/Idle, low in deeper sleep; slow always low.
// R19: Performance regulator mode stays full in all modes.
// R20: Standby stops fast clocks except those with standby-run set.
// R21: Sleep mode field uses distinct codes for Idle, Standby, Power-Down.
module scoc_top (
  // Clock and reset
  input  wire logic                             clk_i,
  input  wire logic                             rst_i,
  // Wishbone slave
  input  wire logic                             wb_cyc_i,
  input  wire logic                             wb_stb_i,
  input  wire logic                             wb_we_i,
  input  wire logic [scoc_pkg::SCOC_ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                       wb_sel_i,
  input  wire logic [31:0]                      wb_dat_i,
  output logic      [31:0]                      wb_dat_o,
  output logic                                  wb_ack_o,
  // CPU side
  input  wire logic                             sleep_instr_i,
  input  wire logic [7:0]                       irq_pending_i,
  input  wire logic                             irq_global_en_i,
  input  wire logic                             reset_src_i,
  output logic                                  cpu_halt_o,
  output logic                                  cpu_wake_irq_o,
  output logic                                  cpu_reset_vector_o,
  // Clock sources
  input  wire logic                             osc_pin_one_i,
  input  wire logic                             crystal_req_i,
  input  wire logic                             main_src_slow_i,
  input  wire logic                             slow_only_i,
  input  wire logic [3:0]                       hf_run_in_standby_i,
  // Oscillator and pin control
  output logic                                  osc_enable_o,
  output logic                                  osc_low_power_o,
  output logic                                  osc_ext_clock_o,
  output logic                                  pin_one_override_o,
  output logic                                  pin_two_override_o,
  output logic                                  crystal_clk_avail_o,
  // Power control
  output logic      [3:0]                       hf_clk_en_o,
  output logic                                  reg_low_power_o,
  output logic      [1:0]                       sleep_state_o
);

  // Any reset source takes registers, timer, sleep state and outputs back to reset; bus, pin synchroniser and cpu_reset_vector_o reset on rst_i only
  logic rst_all;
  assign rst_all = rst_i || reset_src_i; // R13

  function automatic logic adr_hit(input logic [scoc_pkg::SCOC_ADR_W-1:0] adr,
                                   input logic [7:0]                      off);
    adr_hit = (adr == off);
  endfunction

  function automatic logic is_deep(input scoc_pkg::scoc_state_t st);
    is_deep = (st == scoc_pkg::SCOC_ST_STANDBY) || (st == scoc_pkg::SCOC_ST_PDOWN);
  endfunction

  // Registers
  scoc_pkg::scoc_xosc_ctrl_t xosc_r;
  logic                      sleep_enable_r;
  logic [1:0]                sleep_mode_select_r;
  logic                      regulator_power_mode_r;
  scoc_pkg::scoc_state_t     state_r;
  scoc_pkg::scoc_state_t     state_nxt;

  // Bus strobes
  logic bus_req;
  logic wr_en;
  logic lane0;
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en   = bus_req && wb_we_i;
  assign lane0   = wb_sel_i[0];

  // Oscillator pin synchroniser and edge detect
  logic pin_meta_r;
  logic pin_sync_r;
  logic pin_prev_r;
  logic osc_tick;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end
    else
    begin
      pin_meta_r <= osc_pin_one_i;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  assign osc_tick = pin_sync_r && !pin_prev_r;

  // Oscillator status and run decision
  logic        crystal_osc_status;
  logic        clk_avail;
  logic        osc_run;
  logic        ctrl_locked;
  logic [16:0] su_limit;

  assign ctrl_locked = xosc_r.osc_enable || crystal_osc_status; // R5

  always_comb
  begin
    su_limit = scoc_pkg::SCOC_SU_EXT;
    if (!xosc_r.ext_clock_sel)
    begin
      case (xosc_r.crystal_startup_time) // R4
        2'h0:    su_limit = scoc_pkg::SCOC_SU_1K;
        2'h1:    su_limit = scoc_pkg::SCOC_SU_16K;
        2'h2:    su_limit = scoc_pkg::SCOC_SU_32K;
        default: su_limit = scoc_pkg::SCOC_SU_64K;
      endcase
    end
  end

  always_comb
  begin
    osc_run = 1'b0;
    if (xosc_r.osc_enable)
    begin
      if (xosc_r.run_in_standby)
        osc_run = 1'b1; // R2
      else
        osc_run = crystal_req_i && !is_deep(state_r); // R1
    end
  end

  scoc_startup_timer u_timer (
    .clk_i    (clk_i),
    .rst_i    (rst_all),
    .enable_i (xosc_r.osc_enable),
    .run_i    (osc_run),
    .tick_i   (osc_tick),
    .limit_i  (su_limit),
    .req_i    (crystal_req_i),
    .ready_o  (crystal_osc_status),
    .avail_o  (clk_avail)
  );

  // Crystal oscillator control register
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
      xosc_r <= scoc_pkg::scoc_xosc_ctrl_t'(scoc_pkg::SCOC_XOSC_CTRL_RST);
    else if (wr_en && lane0 && adr_hit(wb_adr_i, scoc_pkg::SCOC_OFF_XOSC_CTRL))
    begin
      xosc_r.run_in_standby <= wb_dat_i[scoc_pkg::SCOC_XO_RUN_IN_STANDBY];
      xosc_r.osc_low_power  <= wb_dat_i[scoc_pkg::SCOC_XO_OSC_LOW_POWER]; // R7
      xosc_r.osc_enable     <= wb_dat_i[scoc_pkg::SCOC_XO_ENABLE]; // R8
      if (!ctrl_locked)
      begin
        xosc_r.crystal_startup_time <= wb_dat_i[scoc_pkg::SCOC_XO_CRYSTAL_STARTUP_TIME_LSB +: 2]; // R5
        xosc_r.ext_clock_sel        <= wb_dat_i[scoc_pkg::SCOC_XO_SEL]; // R6
      end
    end
  end

  // Sleep control register; untouched by sleep entry or exit
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      sleep_enable_r      <= scoc_pkg::SCOC_SEN_RST;
      sleep_mode_select_r <= scoc_pkg::SCOC_SLEEP_MODE_SELECT_RST;
    end
    else if (wr_en && lane0 && adr_hit(wb_adr_i, scoc_pkg::SCOC_OFF_SLEEP_CTRL))
    begin
      sleep_enable_r      <= wb_dat_i[scoc_pkg::SCOC_SC_SEN]; // R14
      sleep_mode_select_r <= wb_dat_i[scoc_pkg::SCOC_SC_MODE_LSB +: 2];
    end
  end

  // Regulator control register
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
      regulator_power_mode_r <= scoc_pkg::SCOC_REGULATOR_POWER_MODE_RST;
    else if (wr_en && lane0 && adr_hit(wb_adr_i, scoc_pkg::SCOC_OFF_REG_CTRL))
      regulator_power_mode_r <= wb_dat_i[scoc_pkg::SCOC_RC_REGULATOR_POWER_MODE];
  end

  // Wake detection for the current sleep state
  logic wake_req;

  scoc_wake_filter u_wake (
    .state_i (state_r),
    .irq_i   (irq_pending_i),
    .gie_i   (irq_global_en_i),
    .wake_o  (wake_req)
  );

  // Sleep state machine
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      scoc_pkg::SCOC_ST_ACTIVE:
      begin
        if (sleep_instr_i && sleep_enable_r) // R15
        begin
          case (sleep_mode_select_r) // R21
            scoc_pkg::SCOC_SLEEP_MODE_SELECT_IDLE:  state_nxt = scoc_pkg::SCOC_ST_IDLE; // R9
            scoc_pkg::SCOC_SLEEP_MODE_SELECT_STDBY: state_nxt = scoc_pkg::SCOC_ST_STANDBY;
            scoc_pkg::SCOC_SLEEP_MODE_SELECT_PDOWN: state_nxt = scoc_pkg::SCOC_ST_PDOWN;
            default:                    state_nxt = scoc_pkg::SCOC_ST_ACTIVE;
          endcase
        end
      end
      scoc_pkg::SCOC_ST_IDLE,
      scoc_pkg::SCOC_ST_STANDBY,
      scoc_pkg::SCOC_ST_PDOWN:
      begin
        if (wake_req) // R16
          state_nxt = scoc_pkg::SCOC_ST_ACTIVE; // R11
      end
      default:
        state_nxt = scoc_pkg::SCOC_ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_all)
      state_r <= scoc_pkg::SCOC_ST_ACTIVE; // R13
    else
      state_r <= state_nxt;
  end

  // CPU handshake outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      cpu_halt_o     <= 1'b0;
      cpu_wake_irq_o <= 1'b0;
    end
    else
    begin
      cpu_halt_o     <= (state_nxt != scoc_pkg::SCOC_ST_ACTIVE); // R10
      cpu_wake_irq_o <= (state_r != scoc_pkg::SCOC_ST_ACTIVE) &&
                        (state_nxt == scoc_pkg::SCOC_ST_ACTIVE); // R11
    end
  end

  // Reset vector fetch follows a reset from another source
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cpu_reset_vector_o <= 1'b0;
    else
      cpu_reset_vector_o <= reset_src_i; // R13
  end

  // Oscillator and pin outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      osc_enable_o        <= 1'b0;
      osc_low_power_o     <= 1'b0;
      osc_ext_clock_o     <= 1'b0;
      pin_one_override_o  <= 1'b0;
      pin_two_override_o  <= 1'b0;
      crystal_clk_avail_o <= 1'b0;
    end
    else
    begin
      osc_enable_o        <= osc_run; // R1
      osc_low_power_o     <= xosc_r.osc_low_power; // R7
      osc_ext_clock_o     <= xosc_r.ext_clock_sel; // R6
      pin_one_override_o  <= xosc_r.osc_enable; // R8
      pin_two_override_o  <= xosc_r.osc_enable && !xosc_r.ext_clock_sel; // R6
      crystal_clk_avail_o <= clk_avail; // R3
    end
  end

  // Fast clock gating per sleep state
  logic [3:0] hf_en_nxt;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_hf
      always_comb
      begin
        case (state_r)
          scoc_pkg::SCOC_ST_ACTIVE,
          scoc_pkg::SCOC_ST_IDLE:    hf_en_nxt[g] = 1'b1;
          scoc_pkg::SCOC_ST_STANDBY: hf_en_nxt[g] = hf_run_in_standby_i[g]; // R20
          default:                   hf_en_nxt[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  // Regulator mode; full mode trades sleep current for fast wake-up
  logic reg_low_nxt;

  always_comb
  begin
    reg_low_nxt = 1'b0;
    if (regulator_power_mode_r == scoc_pkg::SCOC_REGULATOR_POWER_MODE_AUTO)
    begin
      if (main_src_slow_i)
        reg_low_nxt = 1'b1; // R18
      else if (is_deep(state_r))
        reg_low_nxt = 1'b1; // R18
      else if ((state_r != scoc_pkg::SCOC_ST_ACTIVE) && slow_only_i)
        reg_low_nxt = 1'b1; // R17
    end
    else
      reg_low_nxt = 1'b0; // R19
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      hf_clk_en_o     <= 4'hF;
      reg_low_power_o <= 1'b0;
      sleep_state_o   <= 2'h0;
    end
    else
    begin
      hf_clk_en_o     <= hf_en_nxt;
      reg_low_power_o <= reg_low_nxt;
      sleep_state_o   <= state_r;
    end
  end

  // Wishbone read data and single-cycle acknowledge
  logic [31:0] rd_nxt;

  always_comb
  begin
    rd_nxt = 32'h00000000;
    if (adr_hit(wb_adr_i, scoc_pkg::SCOC_OFF_XOSC_CTRL))
      rd_nxt = {24'h000000, xosc_r.run_in_standby, 1'b0,
                xosc_r.crystal_startup_time, 1'b0, xosc_r.ext_clock_sel,
                xosc_r.osc_low_power, xosc_r.osc_enable};
    else if (adr_hit(wb_adr_i, scoc_pkg::SCOC_OFF_SLEEP_CTRL))
      rd_nxt = {29'h00000000, sleep_mode_select_r, sleep_enable_r};
    else if (adr_hit(wb_adr_i, scoc_pkg::SCOC_OFF_REG_CTRL))
      rd_nxt = {31'h00000000, regulator_power_mode_r};
    else if (adr_hit(wb_adr_i, scoc_pkg::SCOC_OFF_SLEEP_STAT))
      rd_nxt = {26'h0000000, reg_low_power_o, clk_avail, osc_run,
                cpu_halt_o, state_r};
    else if (adr_hit(wb_adr_i, scoc_pkg::SCOC_OFF_MCLK_STAT))
      rd_nxt = {31'h00000000, crystal_osc_status};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i)
        wb_dat_o <= rd_nxt;
    end
  end

endmodule

/* tb/scoc_osc_model.sv */
module scoc_osc_model (
  // Pin ownership and oscillator run
  input  wire logic pin_owned_i,
  input  wire logic osc_run_i,
  // Oscillator pin
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lvl = 1'b0;
  // Free running, unrelated in phase to the system clock
  always #37 lvl = ~lvl;
  // Swings only while the oscillator owns the pin and runs
  assign pin_o = (pin_owned_i && osc_run_i) ? lvl : 1'b0;
endmodule

/* tb/scoc_monitor.sv */
module scoc_monitor (
  // Clock and resets
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       reset_src_i,
  // Bus
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // CPU side
  input wire logic       sleep_instr_i,
  input wire logic [7:0] irq_pending_i,
  input wire logic       irq_global_en_i,
  input wire logic       cpu_halt_o,
  input wire logic       cpu_wake_irq_o,
  input wire logic       cpu_reset_vector_o,
  // Oscillator and power
  input wire logic       osc_enable_o,
  input wire logic       osc_ext_clock_o,
  input wire logic       pin_one_override_o,
  input wire logic       pin_two_override_o,
  input wire logic [3:0] hf_run_in_standby_i,
  input wire logic [3:0] hf_clk_en_o,
  input wire logic [1:0] sleep_state_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking mon_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || reset_src_i);

  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  a_sleep_needs_instr: assert property ($rose(cpu_halt_o) |-> $past(sleep_instr_i))
    else $error("halt without sleep instruction");
  a_wake_clears_halt: assert property (cpu_halt_o && irq_global_en_i && irq_pending_i[0]
    |=> !cpu_halt_o && cpu_wake_irq_o) else $error("no wake on enabled irq");
  a_wake_single: assert property (cpu_wake_irq_o |=> !cpu_wake_irq_o && !cpu_halt_o)
    else $error("wake pulse too long");
  a_halt_shows_state: assert property ($rose(cpu_halt_o) |=> sleep_state_o != 2'h0)
    else $error("halt without sleep state");
  a_reset_vector_restart: assert property (disable iff (rst_i) reset_src_i |=> cpu_reset_vector_o && !cpu_halt_o)
    else $error("reset did not restart");
  a_pin_two_owner: assert property (pin_two_override_o == (pin_one_override_o && !osc_ext_clock_o))
    else $error("pin two ownership wrong");
  a_osc_needs_pin: assert property ((!pin_one_override_o) [*2] |-> !osc_enable_o)
    else $error("oscillator runs while disabled");
  a_pdown_clocks_off: assert property ((sleep_state_o == 2'h3) [*2] |-> hf_clk_en_o == 4'h0)
    else $error("fast clocks on in power-down");
  a_stdby_clocks_sel: assert property ((sleep_state_o == 2'h2 && $stable(hf_run_in_standby_i)) [*3]
    |-> hf_clk_en_o == hf_run_in_standby_i) else $error("standby clock enables wrong");

  c_standby: cover property (sleep_state_o == 2'h2);
  c_wake: cover property (cpu_wake_irq_o);
  c_restart: cover property (cpu_reset_vector_o);
endmodule

bind scoc_top scoc_monitor u_mon (.clk_i, .rst_i, .reset_src_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sleep_instr_i,
  .irq_pending_i, .irq_global_en_i, .cpu_halt_o, .cpu_wake_irq_o, .cpu_reset_vector_o, .osc_enable_o,
  .osc_ext_clock_o, .pin_one_override_o, .pin_two_override_o, .hf_run_in_standby_i, .hf_clk_en_o, .sleep_state_o);

/* tb/scoc_tb_top.sv */
module scoc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, irq_pending_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0, hf_run_in_standby_i = 4'h0, hf_clk_en_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'h1495;
  logic        sleep_instr_i = 1'b0, irq_global_en_i = 1'b0, reset_src_i = 1'b0, crystal_req_i = 1'b0;
  logic        main_src_slow_i = 1'b0, slow_only_i = 1'b0, osc_pin_one_i, wb_ack_o;
  logic        cpu_halt_o, cpu_wake_irq_o, cpu_reset_vector_o, osc_enable_o, osc_low_power_o, osc_ext_clock_o;
  logic        pin_one_override_o, pin_two_override_o, crystal_clk_avail_o, reg_low_power_o;
  logic [1:0]  sleep_state_o;
  logic [31:0] exp_q[$];
  int          n_fail = 0;
  int          checks_done = 0;

  always #5 clk_i = ~clk_i;

  scoc_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .sleep_instr_i, .irq_pending_i, .irq_global_en_i, .reset_src_i, .cpu_halt_o, .cpu_wake_irq_o,
    .cpu_reset_vector_o, .osc_pin_one_i, .crystal_req_i, .main_src_slow_i, .slow_only_i, .hf_run_in_standby_i,
    .osc_enable_o, .osc_low_power_o, .osc_ext_clock_o, .pin_one_override_o, .pin_two_override_o,
    .crystal_clk_avail_o, .hf_clk_en_o, .reg_low_power_o, .sleep_state_o);
  scoc_osc_model far (.pin_owned_i(pin_one_override_o), .osc_run_i(osc_enable_o), .pin_o(osc_pin_one_i));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Upper byte enables are random: only the low one may matter
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    seed = xs(seed);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= {seed[3:1], 1'b1};
    wb_dat_i <= {seed[31:8], d};
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    chk("ack", 32'h1, 32'(wb_ack_o));
    if (n >= 20)
      end_sim();
    @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wb_rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb_xfer(1'b0, a, 8'h00);
  endtask

  // Read data is judged where it appears, against the oldest note
  always @(negedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
      chk("read data", exp_q.pop_front(), wb_dat_o);

  // Lower bound catches a start-up count that ends early
  task automatic wait_avail(input int lo, input int lim);
    int n;
    n = 0;
    while (crystal_clk_avail_o !== 1'b1 && n < lim)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("avail", 32'h1, 32'(crystal_clk_avail_o));
    chk("avail time", 32'h1, 32'(n >= lo));
    if (n >= lim)
      end_sim();
  endtask

  task automatic sleep_go(input logic [1:0] m, input logic sleep_enable, input logic exp_h);
    wb_xfer(1'b1, 8'h00, {5'h0, m, sleep_enable});
    seed = xs(seed);
    hf_run_in_standby_i <= seed[3:0];
    sleep_instr_i <= 1'b1;
    @(posedge clk_i);
    sleep_instr_i <= 1'b0;
    @(negedge clk_i);
    chk("halt", 32'(exp_h), 32'(cpu_halt_o));
    @(negedge clk_i);
  endtask

  task automatic irq_pulse(input logic [7:0] v, input logic exp_w);
    @(posedge clk_i);
    irq_pending_i <= v;
    @(posedge clk_i);
    @(negedge clk_i);
    chk("wake pulse", 32'(exp_w), 32'(cpu_wake_irq_o));
    @(posedge clk_i);
    irq_pending_i <= 8'h00;
  endtask

  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_rd(8'h1C, 32'h00);
    wb_xfer(1'b1, 8'h40, 8'hFF);
    wb_rd(8'h40, 32'h00);
    wb_xfer(1'b1, 8'h1C, 8'h22);
    wb_rd(8'h1C, 32'h22);
    @(negedge clk_i);
    chk("low power", 32'h1, 32'(osc_low_power_o));
    wb_xfer(1'b1, 8'h1C, 8'h03);
    crystal_req_i <= 1'b1;
    wb_xfer(1'b1, 8'h1C, 8'h37);
    wb_rd(8'h1C, 32'h03);
    @(negedge clk_i);
    chk("pin two", 32'h1, 32'(pin_two_override_o));
    wait_avail(7000, 20000);
    wb_rd(8'h0C, 32'h01);
    @(posedge clk_i);
    crystal_req_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    chk("osc idle", 32'h0, 32'(osc_enable_o));
    @(posedge clk_i);
    crystal_req_i <= 1'b1;
    wait_avail(8, 28);
    @(posedge clk_i);
    irq_global_en_i <= 1'b1;
    for (int m = 0; m < 3; m++)
    begin
      sleep_go(2'(m), 1'b1, 1'b1);
      chk("state", 32'(m + 1), 32'(sleep_state_o));
      @(negedge clk_i);
      chk("hf clk", m == 0 ? 32'hF : m == 1 ? 32'(seed[3:0]) : 32'h0, 32'(hf_clk_en_o));
      chk("osc run", 32'(m == 0), 32'(osc_enable_o));
      chk("reg low", 32'(m != 0), 32'(reg_low_power_o));
      irq_pulse(8'h80, m == 0);
      chk("masked halt", 32'(m != 0), 32'(cpu_halt_o));
      irq_pulse(8'h01, m != 0);
      chk("awake", 32'h0, 32'(cpu_halt_o));
    end
    wb_xfer(1'b1, 8'h04, 8'h01);
    wb_xfer(1'b1, 8'h1C, 8'h83);
    sleep_go(2'h2, 1'b1, 1'b1);
    chk("reg full", 32'h0, 32'(reg_low_power_o));
    irq_pulse(8'h01, 1'b1);
    sleep_go(2'h1, 1'b1, 1'b1);
    chk("osc stdby", 32'h1, 32'(osc_enable_o));
    irq_pulse(8'h01, 1'b1);
    wb_rd(8'h1C, 32'h83);
    sleep_go(2'h1, 1'b0, 1'b0);
    sleep_go(2'h3, 1'b1, 1'b0);
    @(posedge clk_i);
    irq_global_en_i <= 1'b0;
    sleep_go(2'h2, 1'b1, 1'b1);
    irq_pulse(8'h01, 1'b0);
    chk("halt no gie", 32'h1, 32'(cpu_halt_o));
    @(posedge clk_i);
    reset_src_i <= 1'b1;
    @(posedge clk_i);
    reset_src_i <= 1'b0;
    irq_global_en_i <= 1'b1;
    @(negedge clk_i);
    chk("reset vector", 32'h1, 32'(cpu_reset_vector_o));
    chk("halt after reset", 32'h0, 32'(cpu_halt_o));
    wb_rd(8'h1C, 32'h00);
    slow_only_i <= 1'b1;
    sleep_go(2'h0, 1'b1, 1'b1);
    chk("reg slow", 32'h1, 32'(reg_low_power_o));
    irq_pulse(8'h01, 1'b1);
    wb_xfer(1'b1, 8'h1C, 8'h04);
    wb_xfer(1'b1, 8'h1C, 8'h05);
    @(negedge clk_i);
    chk("ext clock", 32'h1, 32'(osc_ext_clock_o));
    chk("pin two ext", 32'h0, 32'(pin_two_override_o));
    chk("pin one", 32'h1, 32'(pin_one_override_o));
    @(posedge clk_i);
    main_src_slow_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk("reg slow src", 32'h1, 32'(reg_low_power_o));
    end_sim();
  end
endmodule
